// ==== src/pst_bank.sv ====
// status and telemetry register bank behind the management command port
`timescale 1ns/10ps

// Notes on behaviour
// RULE_01: summary word returns two bytes; low byte equals the summary byte.
// RULE_02: summary word bit 11 is set while power good is deasserted.
// RULE_03: summary word bit 12 set when any vendor status flag is set.
// RULE_04: summary word bit 13 set when any input warning or fault is set.
// RULE_05: summary word bit 14 set on any output current warning or fault.
// RULE_06: summary word bit 15 set on any output voltage warning or fault.
// RULE_07: output voltage status: UV fault 4, UV warn 5, OV warn 6, OV fault 7.
// RULE_08: output current status: overcurrent warning bit 5, fault bit 7.
// RULE_09: input status: UV fault 4, UV warn 5, OV warn 6, OV fault 7.
// RULE_10: temperature status: external overheat warning bit 6, fault bit 7.
// RULE_11: comm status bit 1 set on bus timeout or format error.
// RULE_12: comm status bit 5 set on a failed packet error check.
// RULE_13: comm status bit 7 set on an invalid or unsupported command.
// RULE_14: vendor status: die overheat warning bit 6, fault bit 7.
// RULE_15: measured input voltage returned as a 16-bit linear word.
// RULE_16: measured output voltage returned as a 16-bit mantissa only.
// RULE_17: output voltage exponent readable as 5-bit field of format register.
// RULE_18: clear faults drops all flags and alert; live conditions re-set.
// RULE_19: unsupported status bits, summary bits 8 to 10 included, read zero.
// RULE_20: flags stay latched after the condition ends, until cleared.
module pst_bank #(
    parameter int DATA_W = 16
) (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    // command port from the link front end
    input wire logic CMD_STB,
    input wire logic CMD_WR,
    input wire logic [7:0] CMD_CODE,
    // response to the link front end
    output logic RSP_VALID,
    output logic RSP_NAK,
    output logic RSP_WIDE,
    output logic [DATA_W-1:0] RSP_DATA,
    // link error events, one-cycle pulses
    input wire logic BUS_TIMEOUT,
    input wire logic BUS_FORMAT_ERR,
    input wire logic BUS_PEC_ERR,
    // output voltage conditions
    input wire logic OUT_V_UNDER_FAULT,
    input wire logic OUT_V_UNDER_WARN,
    input wire logic OUT_V_OVER_WARN,
    input wire logic OUT_V_OVER_FAULT,
    // output current conditions
    input wire logic OUT_I_OVER_WARN,
    input wire logic OUT_I_OVER_FAULT,
    // input voltage conditions
    input wire logic IN_V_UNDER_FAULT,
    input wire logic IN_V_UNDER_WARN,
    input wire logic IN_V_OVER_WARN,
    input wire logic IN_V_OVER_FAULT,
    // temperature conditions
    input wire logic EXT_OVERHEAT_WARN,
    input wire logic EXT_OVERHEAT_FAULT,
    input wire logic DIE_OVERHEAT_WARNING,
    input wire logic DIE_OVERHEAT_FAULT,
    // power state
    input wire logic POWER_GOOD,
    input wire logic OUTPUT_OFF,
    // telemetry
    input wire logic [DATA_W-1:0] VIN_WORD,
    input wire logic [DATA_W-1:0] VOUT_MANTISSA,
    input wire logic [pst_pkg::EXP_W-1:0] VOUT_EXPONENT,
    // alert line, registered, low one cycle after any flag is latched
    output logic ALERT_N
);
    import pst_pkg::*;

    // ------------------------------------------------------------
    // command decoding
    // ------------------------------------------------------------

    // true for codes that answer a read
    function automatic logic code_readable(input logic [7:0] code);
        code_readable = (code == CODE_OUT_V_FORMAT) ||
                        (code == CODE_SUMMARY_BYTE) ||
                        (code == CODE_SUMMARY_WORD) ||
                        (code == CODE_OUT_V_STATUS) ||
                        (code == CODE_OUT_I_STATUS) ||
                        (code == CODE_INPUT_STATUS) ||
                        (code == CODE_TEMP_STATUS) ||
                        (code == CODE_COMM_STATUS) ||
                        (code == CODE_VENDOR_STATUS) ||
                        (code == CODE_MEAS_IN_V) ||
                        (code == CODE_MEAS_OUT_V);
    endfunction : code_readable

    // true for codes whose answer is two bytes
    function automatic logic code_wide(input logic [7:0] code);
        code_wide = (code == CODE_SUMMARY_WORD) ||
                    (code == CODE_MEAS_IN_V) ||
                    (code == CODE_MEAS_OUT_V);
    endfunction : code_wide

    wire read_hit;
    wire clear_hit;
    wire bad_cmd;
    wire rd_wide;

    // request classes
    assign read_hit = CMD_STB && !CMD_WR && code_readable(CMD_CODE);
    assign clear_hit = CMD_STB && CMD_WR &&
                       (CMD_CODE == CODE_CLEAR_FAULTS);
    assign bad_cmd = CMD_STB && !read_hit && !clear_hit; // RULE_13
    assign rd_wide = read_hit && code_wide(CMD_CODE);

    // ------------------------------------------------------------
    // sticky flags
    // ------------------------------------------------------------
    pst_flags_if #(.W(FLAG_COUNT)) fl ();

    wire [FLAG_COUNT-1:0] f;

    assign f = fl.flags;

    // live conditions and events feeding the latch
    assign fl.cond[F_OV_UV_FLT] = OUT_V_UNDER_FAULT;
    assign fl.cond[F_OV_UV_WRN] = OUT_V_UNDER_WARN;
    assign fl.cond[F_OV_OV_WRN] = OUT_V_OVER_WARN;
    assign fl.cond[F_OV_OV_FLT] = OUT_V_OVER_FAULT;
    assign fl.cond[F_OC_WRN] = OUT_I_OVER_WARN;
    assign fl.cond[F_OC_FLT] = OUT_I_OVER_FAULT;
    assign fl.cond[F_IN_UV_FLT] = IN_V_UNDER_FAULT;
    assign fl.cond[F_IN_UV_WRN] = IN_V_UNDER_WARN;
    assign fl.cond[F_IN_OV_WRN] = IN_V_OVER_WARN;
    assign fl.cond[F_IN_OV_FLT] = IN_V_OVER_FAULT;
    assign fl.cond[F_EXT_WRN] = EXT_OVERHEAT_WARN;
    assign fl.cond[F_EXT_FLT] = EXT_OVERHEAT_FAULT;
    assign fl.cond[F_COM_BUS] = BUS_TIMEOUT || BUS_FORMAT_ERR; // RULE_11
    assign fl.cond[F_COM_PEC] = BUS_PEC_ERR; // RULE_12
    assign fl.cond[F_COM_CMD] = bad_cmd; // RULE_13
    assign fl.cond[F_DIE_WRN] = DIE_OVERHEAT_WARNING;
    assign fl.cond[F_DIE_FLT] = DIE_OVERHEAT_FAULT;

    // clear command, an event in the same cycle still sets
    assign fl.clear = clear_hit; // RULE_18

    pst_flag_latch #(
        .W(FLAG_COUNT)
    ) u_latch (
        .clk(REF_CLK),
        .rst(SYS_RST),
        .fl(fl)
    );

    // ------------------------------------------------------------
    // category registers, unused bits held at zero
    // ------------------------------------------------------------
    logic [7:0] out_v_status;
    logic [7:0] out_i_status;
    logic [7:0] input_status;
    logic [7:0] temp_status;
    logic [7:0] comm_status;
    logic [7:0] vendor_status;

    // output voltage status
    always_comb begin
        out_v_status = 8'h00; // RULE_19
        out_v_status[B_UV_FLT] = f[F_OV_UV_FLT]; // RULE_07
        out_v_status[B_UV_WRN] = f[F_OV_UV_WRN]; // RULE_07
        out_v_status[B_OV_WRN] = f[F_OV_OV_WRN]; // RULE_07
        out_v_status[B_OV_FLT] = f[F_OV_OV_FLT]; // RULE_07
    end

    // output current status
    always_comb begin
        out_i_status = 8'h00; // RULE_19
        out_i_status[B_OC_WRN] = f[F_OC_WRN]; // RULE_08
        out_i_status[B_OC_FLT] = f[F_OC_FLT]; // RULE_08
    end

    // input status
    always_comb begin
        input_status = 8'h00; // RULE_19
        input_status[B_UV_FLT] = f[F_IN_UV_FLT]; // RULE_09
        input_status[B_UV_WRN] = f[F_IN_UV_WRN]; // RULE_09
        input_status[B_OV_WRN] = f[F_IN_OV_WRN]; // RULE_09
        input_status[B_OV_FLT] = f[F_IN_OV_FLT]; // RULE_09
    end

    // external temperature status
    always_comb begin
        temp_status = 8'h00; // RULE_19
        temp_status[B_TEMP_WRN] = f[F_EXT_WRN]; // RULE_10
        temp_status[B_TEMP_FLT] = f[F_EXT_FLT]; // RULE_10
    end

    // communication status
    always_comb begin
        comm_status = 8'h00; // RULE_19
        comm_status[B_COM_BUS] = f[F_COM_BUS]; // RULE_11
        comm_status[B_COM_PEC] = f[F_COM_PEC]; // RULE_12
        comm_status[B_COM_CMD] = f[F_COM_CMD]; // RULE_13
    end

    // vendor status, die temperature
    always_comb begin
        vendor_status = 8'h00; // RULE_19
        vendor_status[B_TEMP_WRN] = f[F_DIE_WRN]; // RULE_14
        vendor_status[B_TEMP_FLT] = f[F_DIE_FLT]; // RULE_14
    end

    // ------------------------------------------------------------
    // summary byte and word
    // ------------------------------------------------------------
    wire other_any;
    logic [7:0] summary_byte;
    logic [15:0] summary_word;
    logic [7:0] out_v_format;

    // flags that no dedicated summary byte bit reports
    assign other_any = f[F_OV_UV_FLT] || f[F_OV_UV_WRN] ||
                       f[F_OV_OV_WRN] || f[F_OC_WRN] ||
                       f[F_IN_UV_WRN] || f[F_IN_OV_WRN] ||
                       f[F_IN_OV_FLT] || (|vendor_status);

    // summary byte, busy bit always zero
    always_comb begin
        summary_byte = 8'h00; // RULE_19
        summary_byte[B_SB_OTHER] = other_any;
        summary_byte[B_SB_COMM] = |comm_status;
        summary_byte[B_SB_TEMP] = |temp_status;
        summary_byte[B_SB_IN_UV] = f[F_IN_UV_FLT];
        summary_byte[B_SB_OC] = f[F_OC_FLT];
        summary_byte[B_SB_OV] = f[F_OV_OV_FLT];
        summary_byte[B_SB_OFF] = OUTPUT_OFF;
    end

    // summary word, bits 8 to 10 always zero
    always_comb begin
        summary_word = 16'h0000; // RULE_19
        summary_word[7:0] = summary_byte; // RULE_01
        summary_word[B_SW_PG_N] = !POWER_GOOD; // RULE_02
        summary_word[B_SW_VENDOR] = |vendor_status; // RULE_03
        summary_word[B_SW_INPUT] = |input_status; // RULE_04
        summary_word[B_SW_IOUT] = |out_i_status; // RULE_05
        summary_word[B_SW_VOUT] = |out_v_status; // RULE_06
    end

    // output voltage format: linear mode, exponent in low bits
    assign out_v_format = {FORMAT_LINEAR, VOUT_EXPONENT}; // RULE_17

    // ------------------------------------------------------------
    // read data selection
    // ------------------------------------------------------------
    logic [DATA_W-1:0] rd_data;

    // narrow registers sit in the low byte
    always_comb begin
        rd_data = DATA_W'(DATA_RESET);
        unique case (CMD_CODE)
            CODE_OUT_V_FORMAT: rd_data = DATA_W'(out_v_format);
            CODE_SUMMARY_BYTE: rd_data = DATA_W'(summary_byte);
            CODE_SUMMARY_WORD: rd_data = DATA_W'(summary_word); // RULE_01
            CODE_OUT_V_STATUS: rd_data = DATA_W'(out_v_status);
            CODE_OUT_I_STATUS: rd_data = DATA_W'(out_i_status);
            CODE_INPUT_STATUS: rd_data = DATA_W'(input_status);
            CODE_TEMP_STATUS: rd_data = DATA_W'(temp_status);
            CODE_COMM_STATUS: rd_data = DATA_W'(comm_status);
            CODE_VENDOR_STATUS: rd_data = DATA_W'(vendor_status);
            CODE_MEAS_IN_V: rd_data = VIN_WORD; // RULE_15
            CODE_MEAS_OUT_V: rd_data = VOUT_MANTISSA; // RULE_16
            default: rd_data = DATA_W'(DATA_RESET);
        endcase
    end

    wire [DATA_W-1:0] next_rsp_data;

    // writes and refused codes answer with zero data
    assign next_rsp_data = read_hit ? rd_data : DATA_W'(DATA_RESET);

    // ------------------------------------------------------------
    // response registers
    // ------------------------------------------------------------

    // one response per taken request, one cycle later
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            RSP_VALID <= 1'b0;
            RSP_NAK <= 1'b0;
            RSP_WIDE <= 1'b0;
            RSP_DATA <= DATA_W'(DATA_RESET);
        end else begin
            RSP_VALID <= CMD_STB;
            RSP_NAK <= bad_cmd; // RULE_13
            RSP_WIDE <= rd_wide;
            RSP_DATA <= next_rsp_data;
        end
    end

    // ------------------------------------------------------------
    // alert line
    // ------------------------------------------------------------

    // follows the latched flags one cycle behind
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            ALERT_N <= 1'b1;
        end else begin
            ALERT_N <= !(|f); // RULE_18
        end
    end

endmodule : pst_bank

// ==== src/pst_pkg.sv ====
// constants shared by the status and telemetry bank
package pst_pkg;

    // ------------------------------------------------------------
    // command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CODE_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CODE_OUT_V_FORMAT = 8'h20;
    localparam logic [7:0] CODE_SUMMARY_BYTE = 8'h78;
    localparam logic [7:0] CODE_SUMMARY_WORD = 8'h79;
    localparam logic [7:0] CODE_OUT_V_STATUS = 8'h7A;
    localparam logic [7:0] CODE_OUT_I_STATUS = 8'h7B;
    localparam logic [7:0] CODE_INPUT_STATUS = 8'h7C;
    localparam logic [7:0] CODE_TEMP_STATUS = 8'h7D;
    localparam logic [7:0] CODE_COMM_STATUS = 8'h7E;
    localparam logic [7:0] CODE_VENDOR_STATUS = 8'h80;
    localparam logic [7:0] CODE_MEAS_IN_V = 8'h88;
    localparam logic [7:0] CODE_MEAS_OUT_V = 8'h8B;

    // ------------------------------------------------------------
    // index of each latched flag in the flag vector
    // ------------------------------------------------------------
    localparam int FLAG_COUNT = 17;
    localparam int F_OV_UV_FLT = 0;
    localparam int F_OV_UV_WRN = 1;
    localparam int F_OV_OV_WRN = 2;
    localparam int F_OV_OV_FLT = 3;
    localparam int F_OC_WRN = 4;
    localparam int F_OC_FLT = 5;
    localparam int F_IN_UV_FLT = 6;
    localparam int F_IN_UV_WRN = 7;
    localparam int F_IN_OV_WRN = 8;
    localparam int F_IN_OV_FLT = 9;
    localparam int F_EXT_WRN = 10;
    localparam int F_EXT_FLT = 11;
    localparam int F_COM_BUS = 12;
    localparam int F_COM_PEC = 13;
    localparam int F_COM_CMD = 14;
    localparam int F_DIE_WRN = 15;
    localparam int F_DIE_FLT = 16;

    // ------------------------------------------------------------
    // bit positions inside the readable registers
    // ------------------------------------------------------------
    localparam int B_UV_FLT = 4;
    localparam int B_UV_WRN = 5;
    localparam int B_OV_WRN = 6;
    localparam int B_OV_FLT = 7;
    localparam int B_OC_WRN = 5;
    localparam int B_OC_FLT = 7;
    localparam int B_TEMP_WRN = 6;
    localparam int B_TEMP_FLT = 7;
    localparam int B_COM_BUS = 1;
    localparam int B_COM_PEC = 5;
    localparam int B_COM_CMD = 7;
    localparam int B_SB_OTHER = 0;
    localparam int B_SB_COMM = 1;
    localparam int B_SB_TEMP = 2;
    localparam int B_SB_IN_UV = 3;
    localparam int B_SB_OC = 4;
    localparam int B_SB_OV = 5;
    localparam int B_SB_OFF = 6;
    localparam int B_SW_PG_N = 11;
    localparam int B_SW_VENDOR = 12;
    localparam int B_SW_INPUT = 13;
    localparam int B_SW_IOUT = 14;
    localparam int B_SW_VOUT = 15;
    localparam int EXP_W = 5;
    localparam logic [2:0] FORMAT_LINEAR = 3'h0;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [FLAG_COUNT-1:0] FLAGS_RESET = 17'h00000;
    localparam logic [15:0] DATA_RESET = 16'h0000;

endpackage : pst_pkg

// ==== src/pst_flags_if.sv ====
// carrier between the bank and its flag latch
`timescale 1ns/10ps
interface pst_flags_if #(
    parameter int W = pst_pkg::FLAG_COUNT
);
    logic [W-1:0] cond;
    logic clear;
    logic [W-1:0] flags;

    modport bank (output cond, output clear, input flags);
    modport latch (input cond, input clear, output flags);
endinterface : pst_flags_if

// ==== src/pst_flag_latch.sv ====
// sticky flag latch with clear, set winning over clear
`timescale 1ns/10ps
module pst_flag_latch #(
    parameter int W = pst_pkg::FLAG_COUNT
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // flag carrier
    pst_flags_if.latch fl
);
    import pst_pkg::*;

    logic [W-1:0] flags;
    logic [W-1:0] next_flags;

    // --------------------------------------------------------
    // next value: clear drops old flags, live conditions re-set
    // --------------------------------------------------------
    assign next_flags = (fl.clear ? '0 : flags) | fl.cond; // RULE_18 RULE_20

    // flag register
    always_ff @(posedge clk) begin
        if (rst) begin
            flags <= W'(FLAGS_RESET);
        end else begin
            flags <= next_flags; // RULE_20
        end
    end

    assign fl.flags = flags;

endmodule : pst_flag_latch

// ==== test/pst_bank_sva.sv ====
// assertion checker for the status and telemetry bank ports
`timescale 1ns/10ps
module pst_bank_sva (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    // command port and response
    input wire logic CMD_STB,
    input wire logic CMD_WR,
    input wire logic [7:0] CMD_CODE,
    input wire logic RSP_VALID,
    input wire logic RSP_NAK,
    input wire logic RSP_WIDE,
    input wire logic [15:0] RSP_DATA,
    // watched conditions, telemetry and alert
    input wire logic POWER_GOOD,
    input wire logic OUT_V_OVER_FAULT,
    input wire logic DIE_OVERHEAT_FAULT,
    input wire logic [15:0] VOUT_MANTISSA,
    input wire logic ALERT_N
);
    // ------------------------------------------------------------
    // request decode
    // ------------------------------------------------------------
    wire logic rd = CMD_STB && !CMD_WR;
    wire logic rd_word = rd && CMD_CODE == 8'h79;
    wire logic rd_vout = rd && CMD_CODE == 8'h7A;
    wire logic rd_comm = rd && CMD_CODE == 8'h7E;
    wire logic rd_vend = rd && CMD_CODE == 8'h80;
    wire logic rd_meas = rd && CMD_CODE == 8'h8B;
    wire logic rd_narrow = rd && CMD_CODE >= 8'h7A && CMD_CODE <= 8'h7E;
    wire logic clr = CMD_STB && CMD_WR && CMD_CODE == 8'h03;
    wire logic bad_wr = CMD_STB && CMD_WR && CMD_CODE != 8'h03;

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);

    // ------------------------------------------------------------
    // response checks
    // ------------------------------------------------------------
    AST_WORD_WIDE: assert property (
        rd_word |=> RSP_VALID && RSP_WIDE && !RSP_NAK)
        else $error("summary word not answered as two bytes");
    AST_WORD_RSVD: assert property (
        rd_word |=> RSP_DATA[10:8] == 3'h0)
        else $error("summary word bits 8 to 10 not zero");
    AST_WORD_PG: assert property (
        rd_word |=> RSP_DATA[11] == !$past(POWER_GOOD))
        else $error("summary word bit 11 wrong for power good");
    AST_NARROW: assert property (
        rd_narrow |=> !RSP_WIDE && RSP_DATA[15:8] == 8'h00)
        else $error("status byte answer not narrow");
    AST_OVF_SET: assert property (
        OUT_V_OVER_FAULT ##1 rd_vout |=> RSP_DATA[7])
        else $error("output overvoltage fault not flagged");
    AST_DIE_SET: assert property (
        DIE_OVERHEAT_FAULT ##1 rd_vend |=> RSP_DATA[7])
        else $error("die overheat fault not flagged");
    AST_BAD_NAK: assert property (
        bad_wr |=> RSP_VALID && RSP_NAK && RSP_DATA == 16'h0000)
        else $error("unsupported write not refused");
    AST_BAD_FLAG: assert property (
        bad_wr ##1 rd_comm |=> RSP_DATA[7])
        else $error("unsupported command not flagged");
    AST_CLEAR_ACK: assert property (
        clr |=> RSP_VALID && !RSP_NAK && RSP_DATA == 16'h0000)
        else $error("clear command not accepted");
    AST_VOUT_WORD: assert property (
        rd_meas |=> RSP_DATA == $past(VOUT_MANTISSA))
        else $error("output voltage word not the mantissa");
    AST_ALERT: assert property (
        OUT_V_OVER_FAULT |-> ##2 !ALERT_N)
        else $error("alert not raised for a latched fault");
endmodule : pst_bank_sva

bind pst_bank pst_bank_sva u_sva (
    .REF_CLK(REF_CLK),
    .SYS_RST(SYS_RST),
    .CMD_STB(CMD_STB),
    .CMD_WR(CMD_WR),
    .CMD_CODE(CMD_CODE),
    .RSP_VALID(RSP_VALID),
    .RSP_NAK(RSP_NAK),
    .RSP_WIDE(RSP_WIDE),
    .RSP_DATA(RSP_DATA),
    .POWER_GOOD(POWER_GOOD),
    .OUT_V_OVER_FAULT(OUT_V_OVER_FAULT),
    .DIE_OVERHEAT_FAULT(DIE_OVERHEAT_FAULT),
    .VOUT_MANTISSA(VOUT_MANTISSA),
    .ALERT_N(ALERT_N)
);

// ==== test/pst_host.sv ====
// host model driving the management command port
`timescale 1ns/10ps
module pst_host (
    // command port
    output logic stb,
    output logic wr,
    output logic [7:0] code
);
    // idle values before the first request
    initial begin
        stb = 1'b0;
        wr = 1'b0;
        code = 8'h00;
    end

    // raise one request, held until the caller moves on
    task automatic drive(input logic w, input logic [7:0] c);
        stb = 1'b1;
        wr = w;
        code = c;
    endtask : drive

    // release, leaving scrambled qualifiers behind
    task automatic rest();
        stb = 1'b0;
        wr = ~wr;
        code = ~code;
    endtask : rest
endmodule : pst_host

// ==== test/tb_top.sv ====
// self-checking bench for the status and telemetry bank
`timescale 1ns/10ps
module tb_top;
    import pst_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [17:0] cond = 18'h00000;
    logic power_good = 1'b1;
    logic output_off = 1'b0;
    logic [15:0] vin_word = 16'h0000;
    logic [15:0] vout_man = 16'h0000;
    logic [4:0] vout_exp = 5'h00;
    logic [16:0] lat;
    wire logic stb, wr, rsp_valid, rsp_nak, rsp_wide, alert_n;
    wire logic [7:0] code;
    wire logic [15:0] rsp_data;
    logic [17:0] expq[$];
    logic [7:0] codes[11] = '{8'h20, 8'h78, 8'h79, 8'h7A, 8'h7B, 8'h7C,
        8'h7D, 8'h7E, 8'h80, 8'h88, 8'h8B};
    int n_errors = 0;
    int check_count = 0;
    int cyc = 0;
    int seed;

    // free running clock
    always #50 ref_clk = ~ref_clk;

    pst_host host (.stb(stb), .wr(wr), .code(code));

    pst_bank DUT (
        .REF_CLK(ref_clk), .SYS_RST(sys_rst),
        .CMD_STB(stb), .CMD_WR(wr), .CMD_CODE(code),
        .RSP_VALID(rsp_valid), .RSP_NAK(rsp_nak),
        .RSP_WIDE(rsp_wide), .RSP_DATA(rsp_data),
        .BUS_TIMEOUT(cond[12]), .BUS_FORMAT_ERR(cond[17]),
        .BUS_PEC_ERR(cond[13]),
        .OUT_V_UNDER_FAULT(cond[0]), .OUT_V_UNDER_WARN(cond[1]),
        .OUT_V_OVER_WARN(cond[2]), .OUT_V_OVER_FAULT(cond[3]),
        .OUT_I_OVER_WARN(cond[4]), .OUT_I_OVER_FAULT(cond[5]),
        .IN_V_UNDER_FAULT(cond[6]), .IN_V_UNDER_WARN(cond[7]),
        .IN_V_OVER_WARN(cond[8]), .IN_V_OVER_FAULT(cond[9]),
        .EXT_OVERHEAT_WARN(cond[10]), .EXT_OVERHEAT_FAULT(cond[11]),
        .DIE_OVERHEAT_WARNING(cond[15]), .DIE_OVERHEAT_FAULT(cond[16]),
        .POWER_GOOD(power_good), .OUTPUT_OFF(output_off),
        .VIN_WORD(vin_word), .VOUT_MANTISSA(vout_man),
        .VOUT_EXPONENT(vout_exp), .ALERT_N(alert_n)
    );

    // ------------------------------------------------------------
    // reference flags
    // ------------------------------------------------------------
    wire logic [16:0] hit = {cond[16:15], 1'b0, cond[13],
        cond[12] | cond[17], cond[11:0]};
    wire logic refused = stb && (wr ? code != CODE_CLEAR_FAULTS
        : !(code inside {codes}));

    // sticky copy, cleared to the live conditions
    always @(posedge ref_clk) begin
        if (sys_rst)
            lat <= 17'h00000;
        else if (stb && wr && code == CODE_CLEAR_FAULTS)
            lat <= hit;
        else
            lat <= lat | hit | {2'b00, refused, 14'h0000};
    end

    // expected {nak, wide, data} of one request
    function automatic logic [17:0] exp_rsp(input logic w,
        input logic [7:0] c);
        logic [7:0] sb;
        sb = {1'b0, output_off, lat[3], lat[5], lat[6], |lat[11:10],
            |lat[14:12], |{lat[2:0], lat[4], lat[9:7], lat[16:15]}};
        if (w)
            return (c == CODE_CLEAR_FAULTS) ? 18'h00000 : 18'h20000;
        case (c)
            CODE_OUT_V_FORMAT: return {13'h0000, vout_exp};
            CODE_SUMMARY_BYTE: return {10'h000, sb};
            CODE_SUMMARY_WORD: return {2'b01, |lat[3:0], |lat[5:4],
                |lat[9:6], |lat[16:15], ~power_good, 3'h0, sb};
            CODE_OUT_V_STATUS: return {10'h000, lat[3:0], 4'h0};
            CODE_OUT_I_STATUS: return {10'h000, lat[5], 1'b0, lat[4], 5'h00};
            CODE_INPUT_STATUS: return {10'h000, lat[9:6], 4'h0};
            CODE_TEMP_STATUS: return {10'h000, lat[11:10], 6'h00};
            CODE_COMM_STATUS: return {10'h000, lat[14], 1'b0, lat[13],
                3'h0, lat[12], 1'b0};
            CODE_VENDOR_STATUS: return {10'h000, lat[16:15], 6'h00};
            CODE_MEAS_IN_V: return {2'b01, vin_word};
            CODE_MEAS_OUT_V: return {2'b01, vout_man};
            default: return 18'h20000;
        endcase
    endfunction : exp_rsp

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [17:0] e,
        input logic [17:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask : chk

    task automatic put(input logic w, input logic [7:0] c);
        expq.push_back(exp_rsp(w, c));
        host.drive(w, c);
    endtask : put

    task automatic rq(input logic w, input logic [7:0] c);
        @(negedge ref_clk);
        put(w, c);
    endtask : rq

    task automatic idle(input int n);
        @(negedge ref_clk);
        host.rest();
        repeat (n) @(negedge ref_clk);
    endtask : idle

    task automatic read_all();
        foreach (codes[k]) rq(1'b0, codes[k]);
    endtask : read_all

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : report_and_stop

    // response watcher, oldest note first
    always @(negedge ref_clk) begin
        if (rsp_valid === 1'b1) begin
            if (expq.size() == 0)
                chk("response count", 18'h00000, 18'h3FFFF);
            else
                chk("response", expq.pop_front(),
                    {rsp_nak, rsp_wide, rsp_data});
        end
    end

    // hang guard
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 6000) begin
            n_errors++;
            $display("unexpected run length: expected end, seen running");
            report_and_stop();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        seed = $urandom(52577);
        repeat (2) @(negedge ref_clk);
        sys_rst = 1'b0;
        read_all();
        idle(2);
        chk("alert", 18'h00001, {17'h00000, alert_n});
        $display("test reset values done");
        for (int i = 0; i < 18; i++) begin
            @(negedge ref_clk);
            cond = 18'h00001 << i;
            @(negedge ref_clk);
            cond = 18'h00000;
            read_all();
            idle(1);
            chk("alert", 18'(lat == 0), 18'(alert_n));
            rq(1'b1, CODE_CLEAR_FAULTS);
            read_all();
            idle(2);
            chk("alert", 18'h00001, {17'h00000, alert_n});
        end
        $display("test single flags done");
        rq(1'b1, CODE_SUMMARY_WORD);
        rq(1'b0, CODE_CLEAR_FAULTS);
        rq(1'b0, 8'h55);
        rq(1'b0, CODE_COMM_STATUS);
        cond = 18'h00008;
        rq(1'b1, CODE_CLEAR_FAULTS);
        rq(1'b0, CODE_OUT_V_STATUS);
        cond = 18'h00000;
        rq(1'b1, CODE_CLEAR_FAULTS);
        rq(1'b0, CODE_SUMMARY_WORD);
        idle(2);
        $display("test refusal and clear done");
        for (int n = 0; n < 80; n++) begin
            @(negedge ref_clk);
            power_good = 1'($urandom);
            output_off = 1'($urandom);
            vin_word = 16'($urandom);
            vout_man = 16'($urandom);
            vout_exp = 5'($urandom);
            cond = 18'($urandom & $urandom & $urandom);
            put($urandom_range(7, 0) == 0, codes[$urandom_range(10, 0)]);
        end
        cond = 18'h00000;
        idle(4);
        $display("test random traffic done");
        report_and_stop();
    end
endmodule : tb_top
